// file: pwm_timer_pkg.sv
// Constants, register map and field layout of the dual-slope PWM timer
// Operation
// - Phase correct counts up to selected TOP
// - Frequency correct TOP from capture or compare A
// - Count zero to TOP and back, per tick
// - Turn at TOP without a hold, next tick counts down
// - Register TOP ranges three to full 16 bits
// - Phase correct sets overflow flag at bottom
// - Phase correct loads compares at TOP, flags
// - Frequency correct loads at bottom, sets overflow
// - Frequency correct flags TOP source at TOP
// - Compare match sets channel compare flag
// - Fixed TOP masks high compare bits on write
// - Compare above TOP never matches
// - Action two clears up, sets down; three inverts
// - Pin driven only when direction bit set
// - Action two: compare at bottom low, at TOP high; three the reverse
// - Action one toggles A when A is TOP
// - Tick from clock divided by prescaler factor
// - Compare writes go to buffer first
// - Capture/top register takes effect at once
// - Action zero disconnects; one only on A in toggle modes
package pwm_timer_pkg;
	localparam int          DATA_W        = 32;
	localparam int          CNT_W         = 16;
	// Byte offsets of the registers
	localparam logic [7:0]  OFS_CTRL      = 8'h00;
	localparam logic [7:0]  OFS_COMPARE_A = 8'h04;
	localparam logic [7:0]  OFS_COMPARE_B = 8'h08;
	localparam logic [7:0]  OFS_CAP_TOP   = 8'h0C;
	localparam logic [7:0]  OFS_COUNT     = 8'h10;
	localparam logic [7:0]  OFS_FLAGS     = 8'h14;
	// Control register fields
	localparam int          F_WSEL_LSB    = 0;
	localparam int          F_ACTA_LSB    = 4;
	localparam int          F_ACTB_LSB    = 6;
	localparam int          F_PSEL_LSB    = 8;
	localparam int          F_DIRA        = 12;
	localparam int          F_DIRB        = 13;
	localparam logic [13:0] CTRL_MASK     = 14'h37FF;
	// Flag register bits
	localparam int          FL_OVF        = 0;
	localparam int          FL_CMPA       = 1;
	localparam int          FL_CMPB       = 2;
	localparam int          FL_CAP        = 3;
	// Waveform selections
	localparam logic [3:0]  WS_PC8        = 4'h1;
	localparam logic [3:0]  WS_PC9        = 4'h2;
	localparam logic [3:0]  WS_PC10       = 4'h3;
	localparam logic [3:0]  WS_PFC_CAP    = 4'h8;
	localparam logic [3:0]  WS_PFC_CMPA   = 4'h9;
	localparam logic [3:0]  WS_PC_CAP     = 4'hA;
	localparam logic [3:0]  WS_PC_CMPA    = 4'hB;
	// Fixed TOP values and limits
	localparam logic [15:0] TOP_8BIT      = 16'h00FF;
	localparam logic [15:0] TOP_9BIT      = 16'h01FF;
	localparam logic [15:0] TOP_10BIT     = 16'h03FF;
	localparam logic [15:0] TOP_MIN       = 16'h0003;
	localparam logic [15:0] CNT_BOTTOM    = 16'h0000;
	localparam logic [15:0] CNT_FULL      = 16'hFFFF;
	localparam logic [15:0] CNT_ONE       = 16'h0001;
	// Output actions
	localparam logic [1:0]  ACT_OFF       = 2'h0;
	localparam logic [1:0]  ACT_TOGGLE    = 2'h1;
	localparam logic [1:0]  ACT_NONINV    = 2'h2;
	localparam logic [1:0]  ACT_INV       = 2'h3;
	// Prescaler selections and divide-minus-one counts
	localparam logic [2:0]  PS_STOP       = 3'h0;
	localparam logic [2:0]  PS_DIV1       = 3'h1;
	localparam logic [2:0]  PS_DIV8       = 3'h2;
	localparam logic [2:0]  PS_DIV64      = 3'h3;
	localparam logic [2:0]  PS_DIV256     = 3'h4;
	localparam logic [2:0]  PS_DIV1024    = 3'h5;
	localparam logic [9:0]  PM_DIV1       = 10'h000;
	localparam logic [9:0]  PM_DIV8       = 10'h007;
	localparam logic [9:0]  PM_DIV64      = 10'h03F;
	localparam logic [9:0]  PM_DIV256     = 10'h0FF;
	localparam logic [9:0]  PM_DIV1024    = 10'h3FF;
	// AXI responses
	localparam logic [1:0]  RESP_OKAY     = 2'h0;
	localparam logic [1:0]  RESP_SLVERR   = 2'h2;
endpackage : pwm_timer_pkg

// file: dual_slope_pwm_timer16.sv
// Dual-slope 16-bit PWM timer with AXI4-Lite register access
`timescale 1ns/1ps
`default_nettype none
module dual_slope_pwm_timer16 #(
	parameter int ADDR_W = 8
) (
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic [ADDR_W-1:0]                 s_axi_awaddr,
	input  wire logic [2:0]                        s_axi_awprot,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [pwm_timer_pkg::DATA_W-1:0]  s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [ADDR_W-1:0]                 s_axi_araddr,
	input  wire logic [2:0]                        s_axi_arprot,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [pwm_timer_pkg::DATA_W-1:0]       s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	output logic                                   waveform_output_a,
	output logic                                   waveform_output_a_oe,
	output logic                                   waveform_output_b,
	output logic                                   waveform_output_b_oe
);
	import pwm_timer_pkg::*;

	// Address must reach the highest register
	generate
		if (ADDR_W < 5 || ADDR_W > 8) begin : g_bad_addr
			$error("ADDR_W must be 5 to 8");
		end
	endgenerate

	logic              aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [7:0]        aw_addr_reg, aw_addr_next;
	logic [31:0]       w_data_reg, w_data_next;
	logic [3:0]        w_strb_reg, w_strb_next;
	logic              bvalid_reg, bvalid_next, rvalid_reg, rvalid_next;
	logic [1:0]        bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0]       rdata_reg, rdata_next;
	logic [13:0]       ctrl_reg, ctrl_next;
	logic [15:0]       count_reg, count_next, cap_reg, cap_next;
	logic [15:0]       cmp_a_reg, cmp_a_next, cmp_b_reg, cmp_b_next;
	logic [15:0]       buf_a_reg, buf_a_next, buf_b_reg, buf_b_next;
	logic              up_reg, up_next, wave_a_reg, wave_a_next, wave_b_reg, wave_b_next;
	logic [3:0]        flags_reg, flags_next;
	logic [9:0]        presc_reg, presc_next, presc_max;
	logic              wr_fire, tick, run, pc_mode, pfc_mode, fixed_top, toggle_mode;
	logic              at_top, at_bottom, match_a, match_b, up_slope;
	logic [15:0]       top_val, wmask;
	logic [3:0]        wsel;
	logic [1:0]        act_a, act_b;
	logic [2:0]        psel;
	logic [31:0]       wr_merged;
	logic              wr_known;

	assign wsel        = ctrl_reg[F_WSEL_LSB +: 4];
	assign act_a       = ctrl_reg[F_ACTA_LSB +: 2];
	assign act_b       = ctrl_reg[F_ACTB_LSB +: 2];
	assign psel        = ctrl_reg[F_PSEL_LSB +: 3];
	assign pc_mode     = (wsel == WS_PC8) || (wsel == WS_PC9) || (wsel == WS_PC10)
		|| (wsel == WS_PC_CAP) || (wsel == WS_PC_CMPA);
	assign pfc_mode    = (wsel == WS_PFC_CAP) || (wsel == WS_PFC_CMPA);
	assign run         = pc_mode || pfc_mode;
	assign fixed_top   = (wsel == WS_PC8) || (wsel == WS_PC9) || (wsel == WS_PC10);
	assign toggle_mode = (wsel == WS_PC_CMPA) || (wsel == WS_PFC_CMPA);

	// TOP source per waveform selection
	always_comb begin
		unique case (wsel)
			WS_PC8:                  top_val = TOP_8BIT;
			WS_PC9:                  top_val = TOP_9BIT;
			WS_PC10:                 top_val = TOP_10BIT;
			WS_PC_CAP, WS_PFC_CAP:   top_val = cap_reg;
			WS_PC_CMPA, WS_PFC_CMPA: top_val = cmp_a_reg;
			default:                 top_val = CNT_FULL;
		endcase
	end

	// Prescaler: divide-minus-one count for the selected factor
	always_comb begin
		unique case (psel)
			PS_DIV1:    presc_max = PM_DIV1;
			PS_DIV8:    presc_max = PM_DIV8;
			PS_DIV64:   presc_max = PM_DIV64;
			PS_DIV256:  presc_max = PM_DIV256;
			PS_DIV1024: presc_max = PM_DIV1024;
			default:    presc_max = PM_DIV1;
		endcase
	end
	assign tick = (psel >= PS_DIV1) && (psel <= PS_DIV1024) && (presc_reg >= presc_max);

	// Events of the current tick
	assign at_top    = (count_reg == top_val);
	assign at_bottom = (count_reg == CNT_BOTTOM);
	assign match_a   = (count_reg == cmp_a_reg);
	assign match_b   = (count_reg == cmp_b_reg);
	assign up_slope  = at_bottom || (up_reg && !at_top);
	assign wmask     = fixed_top ? top_val : CNT_FULL;
	assign wr_fire   = aw_have_reg && w_have_reg && !bvalid_reg;

	// Next waveform level of one channel on a match
	function automatic logic wave_step(input logic cur, input logic [1:0] act,
		input logic hit, input logic up, input logic tog);
		logic res;
		res = cur;
		if (hit) begin
			unique case (act)
				ACT_NONINV: res = !up;
				ACT_INV:    res = up;
				ACT_TOGGLE: res = tog ? !cur : cur;
				default:    res = cur;
			endcase
		end
		return res;
	endfunction : wave_step

	// Register read mux, also used for byte-lane merging
	function automatic logic [32:0] reg_read(input logic [7:0] a, input logic [13:0] c,
		input logic [15:0] ba, input logic [15:0] bb, input logic [15:0] cp,
		input logic [15:0] cn, input logic [3:0] fl);
		logic [32:0] res;
		res = 33'h000000000;
		unique case (a)
			OFS_CTRL:      res = {1'b1, 18'h00000, c};
			OFS_COMPARE_A: res = {1'b1, 16'h0000, ba};
			OFS_COMPARE_B: res = {1'b1, 16'h0000, bb};
			OFS_CAP_TOP:   res = {1'b1, 16'h0000, cp};
			OFS_COUNT:     res = {1'b1, 16'h0000, cn};
			OFS_FLAGS:     res = {1'b1, 28'h0000000, fl};
			default:       res = 33'h000000000;
		endcase
		return res;
	endfunction : reg_read

	// Merge write data into the old word by byte strobes
	always_comb begin
		logic [32:0] old;
		old = reg_read(aw_addr_reg, ctrl_reg, buf_a_reg, buf_b_reg, cap_reg, count_reg, flags_reg);
		wr_known = old[32]; // Held address names a register
		for (int i = 0; i < 4; i++) begin
			wr_merged[i*8 +: 8] = w_strb_reg[i] ? w_data_reg[i*8 +: 8] : old[i*8 +: 8];
		end
	end

	// Bus handshake: address and data taken in either order, response after both
	always_comb begin
		logic [32:0] rd;
		rd            = reg_read(8'(s_axi_araddr), ctrl_reg, buf_a_reg, buf_b_reg, cap_reg, count_reg, flags_reg);
		aw_have_next  = aw_have_reg;
		aw_addr_next  = aw_addr_reg;
		w_have_next   = w_have_reg;
		w_data_next   = w_data_reg;
		w_strb_next   = w_strb_reg;
		bvalid_next   = bvalid_reg;
		bresp_next    = bresp_reg;
		rvalid_next   = rvalid_reg;
		rresp_next    = rresp_reg;
		rdata_next    = rdata_reg;
		if (s_axi_awvalid && s_axi_awready) begin
			aw_have_next = 1'b1;
			aw_addr_next = 8'(s_axi_awaddr);
		end
		if (s_axi_wvalid && s_axi_wready) begin
			w_have_next = 1'b1;
			w_data_next = s_axi_wdata;
			w_strb_next = s_axi_wstrb;
		end
		if (wr_fire) begin
			aw_have_next = 1'b0;
			w_have_next  = 1'b0;
			bvalid_next  = 1'b1;
			bresp_next   = (aw_addr_reg[1:0] == 2'h0 && wr_known) ? RESP_OKAY : RESP_SLVERR;
		end else if (bvalid_reg && s_axi_bready) begin
			bvalid_next = 1'b0;
		end
		if (s_axi_arvalid && s_axi_arready) begin
			rvalid_next = 1'b1;
			rdata_next  = rd[31:0];
			rresp_next  = rd[32] ? RESP_OKAY : RESP_SLVERR;
		end else if (rvalid_reg && s_axi_rready) begin
			rvalid_next = 1'b0;
		end
	end

	assign s_axi_awready = !aw_have_reg && !bvalid_reg;
	assign s_axi_wready  = !w_have_reg && !bvalid_reg;
	assign s_axi_arready = !rvalid_reg;
	assign s_axi_bvalid  = bvalid_reg;
	assign s_axi_bresp   = bresp_reg;
	assign s_axi_rvalid  = rvalid_reg;
	assign s_axi_rresp   = rresp_reg;
	assign s_axi_rdata   = rdata_reg;

	// Timer core: counting, buffer loads, flags, waveforms and software writes
	always_comb begin
		logic [3:0] set_fl, clr_fl;
		set_fl      = 4'h0;
		clr_fl      = 4'h0;
		ctrl_next   = ctrl_reg;
		count_next  = count_reg;
		up_next     = up_reg;
		cmp_a_next  = cmp_a_reg;
		cmp_b_next  = cmp_b_reg;
		buf_a_next  = buf_a_reg;
		buf_b_next  = buf_b_reg;
		cap_next    = cap_reg;
		wave_a_next = wave_a_reg;
		wave_b_next = wave_b_reg;
		presc_next  = tick ? PM_DIV1 : ((psel == PS_STOP) ? PM_DIV1 : presc_reg + 10'h001);
		if (tick && run) begin
			if (up_reg && at_top) begin
				up_next    = 1'b0;
				count_next = count_reg - CNT_ONE;
			end else if (!up_reg && at_bottom) begin
				up_next    = 1'b1;
				count_next = count_reg + CNT_ONE;
			end else if (up_reg) begin
				count_next = count_reg + CNT_ONE;
			end else begin
				count_next = count_reg - CNT_ONE;
			end
			if ((pc_mode && at_top) || (pfc_mode && at_bottom)) begin
				cmp_a_next = buf_a_reg;
				cmp_b_next = buf_b_reg;
			end
			set_fl[FL_OVF]  = at_bottom;
			set_fl[FL_CMPA] = match_a || (at_top && toggle_mode);
			set_fl[FL_CMPB] = match_b;
			set_fl[FL_CAP]  = at_top && ((wsel == WS_PC_CAP) || (wsel == WS_PFC_CAP));
			wave_a_next = wave_step(wave_a_reg, act_a, match_a, up_slope, toggle_mode);
			wave_b_next = wave_step(wave_b_reg, act_b, match_b, up_slope, 1'b0);
		end
		if (wr_fire) begin
			unique case (aw_addr_reg)
				OFS_CTRL:      ctrl_next  = wr_merged[13:0] & CTRL_MASK;
				OFS_COMPARE_A: buf_a_next = wr_merged[15:0] & wmask;
				OFS_COMPARE_B: buf_b_next = wr_merged[15:0] & wmask;
				OFS_CAP_TOP:   cap_next   = wr_merged[15:0];
				OFS_COUNT:     count_next = wr_merged[15:0];
				OFS_FLAGS:     clr_fl     = wr_merged[3:0];
				default:       clr_fl     = 4'h0;
			endcase
		end
		flags_next = (flags_reg & ~clr_fl) | set_fl; // Set wins over clear
	end

	// Registers of both groups
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_reg <= 1'b0;
			aw_addr_reg <= 8'h00;
			w_have_reg  <= 1'b0;
			w_data_reg  <= 32'h00000000;
			w_strb_reg  <= 4'h0;
			bvalid_reg  <= 1'b0;
			bresp_reg   <= RESP_OKAY;
			rvalid_reg  <= 1'b0;
			rresp_reg   <= RESP_OKAY;
			rdata_reg   <= 32'h00000000;
			ctrl_reg    <= 14'h0000;
			count_reg   <= CNT_BOTTOM;
			up_reg      <= 1'b1;
			cmp_a_reg   <= CNT_BOTTOM;
			cmp_b_reg   <= CNT_BOTTOM;
			buf_a_reg   <= CNT_BOTTOM;
			buf_b_reg   <= CNT_BOTTOM;
			cap_reg     <= CNT_BOTTOM;
			flags_reg   <= 4'h0;
			wave_a_reg  <= 1'b0;
			wave_b_reg  <= 1'b0;
			presc_reg   <= PM_DIV1;
		end else begin
			aw_have_reg <= aw_have_next;
			aw_addr_reg <= aw_addr_next;
			w_have_reg  <= w_have_next;
			w_data_reg  <= w_data_next;
			w_strb_reg  <= w_strb_next;
			bvalid_reg  <= bvalid_next;
			bresp_reg   <= bresp_next;
			rvalid_reg  <= rvalid_next;
			rresp_reg   <= rresp_next;
			rdata_reg   <= rdata_next;
			ctrl_reg    <= ctrl_next;
			count_reg   <= count_next;
			up_reg      <= up_next;
			cmp_a_reg   <= cmp_a_next;
			cmp_b_reg   <= cmp_b_next;
			buf_a_reg   <= buf_a_next;
			buf_b_reg   <= buf_b_next;
			cap_reg     <= cap_next;
			flags_reg   <= flags_next;
			wave_a_reg  <= wave_a_next;
			wave_b_reg  <= wave_b_next;
			presc_reg   <= presc_next;
		end
	end

	// Pin drive: connected action and direction bit both needed
	assign waveform_output_a    = wave_a_reg;
	assign waveform_output_b    = wave_b_reg;
	assign waveform_output_a_oe = ctrl_reg[F_DIRA] && run && (act_a != ACT_OFF)
		&& (act_a != ACT_TOGGLE || toggle_mode);
	assign waveform_output_b_oe = ctrl_reg[F_DIRB] && run && (act_b != ACT_OFF) && (act_b != ACT_TOGGLE);

	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_top_tick;
		tick && run && up_reg && at_top && !wr_fire;
	endsequence
	sequence s_turn_down;
		!up_reg && (count_reg == $past(top_val) - CNT_ONE);
	endsequence

	a_top_reverse: assert property (s_top_tick |=> s_turn_down)
		else $error("counter did not turn at TOP");
	a_count_step: assert property (tick && run && up_reg && !at_top && !wr_fire
		|=> count_reg == $past(count_reg) + CNT_ONE)
		else $error("counter did not step up");
	a_hold_no_tick: assert property (!tick && !wr_fire |=> $stable(count_reg) && $stable(flags_reg))
		else $error("timer state moved without tick");
	a_overflow_bottom: assert property (tick && run && at_bottom |=> flags_reg[FL_OVF])
		else $error("overflow flag not set at bottom");
	a_pc_load_top: assert property (tick && pc_mode && at_top |=> cmp_b_reg == $past(buf_b_reg))
		else $error("compare not loaded at TOP");
	a_pfc_load_bottom: assert property (tick && pfc_mode && at_bottom
		|=> cmp_a_reg == $past(buf_a_reg) && flags_reg[FL_OVF])
		else $error("compare not loaded at bottom");
	a_pfc_no_top_load: assert property (tick && pfc_mode && at_top && !at_bottom |=> $stable(cmp_b_reg))
		else $error("frequency correct mode loaded at TOP");
	a_cap_flag_top: assert property (tick && at_top && (wsel == WS_PC_CAP || wsel == WS_PFC_CAP)
		|=> flags_reg[FL_CAP])
		else $error("capture flag not set at TOP");
	a_match_flag: assert property (tick && run && match_b |=> flags_reg[FL_CMPB])
		else $error("compare flag missed a match");
	a_clear_upcount: assert property (tick && run && match_a && act_a == ACT_NONINV && up_slope
		|=> !wave_a_reg)
		else $error("non-inverted output not cleared on up match");
	a_pin_gate: assert property (!ctrl_reg[F_DIRA] |-> !waveform_output_a_oe)
		else $error("pin driven with direction input");
	a_toggle_a: assert property (tick && run && match_a && act_a == ACT_TOGGLE && toggle_mode
		|=> wave_a_reg != $past(wave_a_reg))
		else $error("output A did not toggle");
	a_tick_spacing: assert property (tick && psel == PS_DIV8 && !wr_fire
		|=> (!tick || psel != PS_DIV8) [*7])
		else $error("tick spacing wrong for divide by eight");
endmodule : dual_slope_pwm_timer16
`default_nettype wire

// file: pin_load_model.sv
// Load on one waveform pin: resolves the pin and measures its level and period
`timescale 1ns/1ps
`default_nettype none
module pin_load_model (
	input  wire logic        aclk,
	input  wire logic        drive,
	input  wire logic        drive_en,
	input  wire logic        clear,
	output logic [15:0]      high_cnt,
	output logic [15:0]      low_cnt,
	output logic [15:0]      period
);
	logic        pin_level;
	logic        prev_level;
	logic [15:0] since_rise;

	// Pull-down holds the pin low whenever the device releases it
	assign pin_level = drive_en ? drive : 1'b0;

	// Level counts and rising-edge to rising-edge distance
	always @(posedge aclk) begin
		if (clear) begin
			high_cnt   <= 16'h0000;
			low_cnt    <= 16'h0000;
			period     <= 16'h0000;
			since_rise <= 16'h0000;
		end else begin
			if (pin_level) high_cnt <= high_cnt + 16'h0001;
			else low_cnt <= low_cnt + 16'h0001;
			since_rise <= (pin_level && !prev_level) ? 16'h0000 : since_rise + 16'h0001;
			if (pin_level && !prev_level) period <= since_rise + 16'h0001;
		end
		prev_level <= pin_level;
	end
endmodule : pin_load_model
`default_nettype wire

// file: dual_slope_pwm_timer16_tb_top.sv
// Self-checking bench for the dual-slope PWM timer over its register bus
`timescale 1ns/1ps
`default_nettype none
module dual_slope_pwm_timer16_tb_top;
	import pwm_timer_pkg::*;
	logic        aclk = 1'b0, aresetn = 1'b0, clr = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic        awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, bready = 1'b1, rready = 1'b1;
	logic [31:0] wdata = 32'h0, rdata;
	logic [1:0]  bresp, rresp, rs;
	logic        awready, wready, bvalid, arready, rvalid, out_a, oe_a, out_b, oe_b;
	logic [15:0] hi_a, lo_a, per_a, hi_b, lo_b, per_b;
	int          num_errors = 0, cmp_count = 0;

	// Free-running bus clock
	always #2 aclk = ~aclk;

	dual_slope_pwm_timer16 u_dual_slope_pwm_timer16 (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awprot(3'h0), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arprot(3'h0), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.waveform_output_a(out_a), .waveform_output_a_oe(oe_a),
		.waveform_output_b(out_b), .waveform_output_b_oe(oe_b));
	pin_load_model u_pin_load_model_a (.aclk(aclk), .drive(out_a), .drive_en(oe_a), .clear(clr),
		.high_cnt(hi_a), .low_cnt(lo_a), .period(per_a));
	pin_load_model u_pin_load_model_b (.aclk(aclk), .drive(out_b), .drive_en(oe_b), .clear(clr),
		.high_cnt(hi_b), .low_cnt(lo_b), .period(per_b));

	task automatic tally_and_finish();
		$display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
		if (num_errors == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : tally_and_finish

	task automatic guard(inout int n);
		n++;
		if (n > 200) begin
			num_errors++;
			$display("CHECK FAILED bus handshake expected within 200 cycles seen none");
			tally_and_finish();
		end
	endtask : guard

	task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			num_errors++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask : chk_word

	task automatic chk_resp(input string nm, input logic [1:0] e, input logic [1:0] g);
		chk_word(nm, {30'h0, e}, {30'h0, g});
	endtask : chk_resp

	task automatic chk_num(input string nm, input logic [15:0] e, input logic [15:0] g);
		chk_word(nm, {16'h0, e}, {16'h0, g});
	endtask : chk_num

	// Address and data offered together, each released once taken
	task automatic axi_write(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		bit aw_hit, w_hit, aw_done, w_done;
		int n;
		aw_done = 0;
		w_done = 0;
		n = 0;
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		while (!(aw_done && w_done)) begin
			@(negedge aclk);
			aw_hit = awvalid && awready;
			w_hit = wvalid && wready;
			@(posedge aclk);
			if (aw_hit) begin
				awvalid <= 1'b0;
				aw_done = 1;
			end
			if (w_hit) begin
				wvalid <= 1'b0;
				w_done = 1;
			end
			guard(n);
		end
		do begin
			@(negedge aclk);
			aw_hit = bvalid;
			r = bresp;
			@(posedge aclk);
			guard(n);
		end while (!aw_hit);
	endtask : axi_write

	task automatic axi_read(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		bit hit;
		int n;
		n = 0;
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(negedge aclk);
			hit = arready;
			@(posedge aclk);
			guard(n);
		end while (!hit);
		arvalid <= 1'b0;
		do begin
			@(negedge aclk);
			hit = rvalid;
			d = rdata;
			r = rresp;
			@(posedge aclk);
			guard(n);
		end while (!hit);
	endtask : axi_read

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axi_write(a, d, rs);
		chk_resp("write response", RESP_OKAY, rs);
	endtask : wr

	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		axi_read(a, d, rs);
		chk_resp("read response", RESP_OKAY, rs);
		chk_word("read data", e, d);
	endtask : rd_chk

	// Let the waveform settle for n cycles, then count over the next n
	task automatic measure(input int n);
		repeat (n) @(posedge aclk);
		clr <= 1'b1;
		@(posedge aclk);
		clr <= 1'b0;
		// One extra edge so the last counted sample has settled in the load
		repeat (n + 1) @(posedge aclk);
	endtask : measure

	function automatic logic [31:0] ctl(input logic [3:0] m, input logic [1:0] aa, input logic [1:0] ab,
		input logic [2:0] p);
		ctl = 32'(m) | (32'(aa) << F_ACTA_LSB) | (32'(ab) << F_ACTB_LSB) | (32'(p) << F_PSEL_LSB)
			| (32'h1 << F_DIRA) | (32'h1 << F_DIRB);
	endfunction : ctl

	// Main sequence
	initial begin
		logic [3:0]  modes [4] = '{WS_PC_CAP, WS_PFC_CAP, WS_PC_CMPA, WS_PFC_CMPA};
		logic [15:0] tops [3] = '{TOP_8BIT, TOP_9BIT, TOP_10BIT};
		logic [15:0] divs [3] = '{16'd64, 16'd256, 16'd1024};
		logic [31:0] d;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		@(posedge aclk);
		rd_chk(OFS_CTRL, 32'h0);
		rd_chk(OFS_FLAGS, 32'h0);
		axi_read(8'h18, d, rs);
		chk_resp("unmapped read", RESP_SLVERR, rs);
		axi_write(8'h1C, 32'h1, rs);
		chk_resp("unmapped write", RESP_SLVERR, rs);
		wr(OFS_CAP_TOP, 32'h3);
		rd_chk(OFS_CAP_TOP, 32'h3);
		wr(OFS_COMPARE_A, 32'h3);
		wr(OFS_COMPARE_B, 32'h1);
		// Each selection with TOP from capture or compare A, set to three, gives six ticks per period
		foreach (modes[i]) begin
			wr(OFS_CTRL, ctl(modes[i], ACT_OFF, ACT_NONINV, PS_DIV1));
			measure(60);
			chk_num("period b", 16'd6, per_b);
			chk_num("high time b", 16'd20, hi_b);
		end
		chk_num("pin a enable", 16'd0, {15'h0, oe_a});
		chk_num("pin b enable", 16'd1, {15'h0, oe_b});
		rd_chk(OFS_FLAGS, 32'hF);
		// Compare above TOP never matches
		wr(OFS_COMPARE_B, 32'h5);
		measure(30);
		wr(OFS_FLAGS, 32'hF);
		measure(30);
		rd_chk(OFS_FLAGS, 32'h3);
		// Extreme compare values for both polarities
		for (int i = 0; i < 4; i++) begin
			wr(OFS_COMPARE_B, i[0] ? 32'h3 : 32'h0);
			wr(OFS_CTRL, ctl(WS_PFC_CMPA, ACT_OFF, i[1] ? ACT_INV : ACT_NONINV, PS_DIV1));
			measure(60);
			chk_num("constant level", 16'd0, (i[0] ^ i[1]) ? lo_b : hi_b);
		end
		wr(OFS_COMPARE_B, 32'h1);
		wr(OFS_CTRL, ctl(WS_PFC_CMPA, ACT_OFF, ACT_INV, PS_DIV1));
		measure(60);
		chk_num("inverted high time", 16'd40, hi_b);
		wr(OFS_CTRL, ctl(WS_PFC_CMPA, ACT_OFF, ACT_NONINV, PS_DIV8));
		measure(240);
		chk_num("divided period", 16'd48, per_b);
		chk_num("divided high time", 16'd80, hi_b);
		// Larger prescaler factors: period is six ticks of N clocks
		for (int k = 0; k < 3; k++) begin
			wr(OFS_CTRL, ctl(WS_PFC_CMPA, ACT_OFF, ACT_NONINV, PS_DIV64 + 3'(k)));
			measure(12 * int'(divs[k]));
			chk_num("prescaled period", 16'(6 * int'(divs[k])), per_b);
		end
		// Toggle on channel A when compare A is TOP
		wr(OFS_CTRL, ctl(WS_PC_CMPA, ACT_TOGGLE, ACT_NONINV, PS_DIV1));
		measure(60);
		chk_num("toggle period", 16'd12, per_a);
		chk_num("toggle high time", 16'd30, hi_a);
		// TOP changed while running, in frequency correct mode as software should
		wr(OFS_CTRL, ctl(WS_PFC_CAP, ACT_OFF, ACT_NONINV, PS_DIV1));
		wr(OFS_CAP_TOP, 32'h5);
		measure(60);
		chk_num("new TOP period", 16'd10, per_b);
		chk_num("new TOP high time", 16'd12, hi_b);
		// Fixed TOP masks compare bits; stopped prescaler freezes the count
		foreach (tops[j]) begin
			wr(OFS_CTRL, ctl(WS_PC8 + 4'(j), ACT_NONINV, ACT_NONINV, PS_STOP));
			wr(OFS_COMPARE_A, 32'h0000FFFF);
			rd_chk(OFS_COMPARE_A, {16'h0, tops[j]});
		end
		wr(OFS_COUNT, 32'h2);
		measure(20);
		rd_chk(OFS_COUNT, 32'h2);
		tally_and_finish();
	end
endmodule : dual_slope_pwm_timer16_tb_top
`default_nettype wire
